// ### hw/asq_sequencer.sv
// Purpose: four-sequence converter control with arbiter, averaging and fifos
// Assumes: converter core answers each conv_start with one conv_done pulse
// Notes: all control bits are plain ports; ext_trig_pin is asynchronous
//
// Summary of operation
// - each conversion picks one of eight channels or the temperature sensor
// - four sequencers, each launched by its own selected trigger
// - sequencer depths are eight, four, four and one steps
// - every step chooses its own input freely
// - arbiter grants the pending sequencer with the best priority
// - averaging factors 2x to 64x, conversions per result scale likewise
// - a result is the mean of consecutive conversions of one input
// - one averaging setting serves all sequencers
// - averaging factor zero delivers every conversion unaveraged
// - averaging uses no steps or fifo slots; one entry per step
// - sequencer interrupt stays low after clear until a new event
// - each sequencer interrupt has its own mask bit
// - opening a mask clears stale pending status first
// - raw and masked interrupt status both reported
// - processor trigger acts only when the source is processor
// - priority 0 highest to 3 lowest, unique per sequencer
// - sources are processor, external pin, timer and always
// - trigger with unread results sets sticky overflow until cleared
// - step holds channel, differential, temperature, last and interrupt bits
`timescale 1ns/1ps
`default_nettype none
`include "asq_cfg.svh"
module asq_sequencer #(
  parameter int SAMPLE_W = `ASQ_SAMPLE_W
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [3:0] seq_enable,
  input wire logic [7:0] trig_source,
  input wire logic [7:0] sequencer_priority,
  input wire logic [3:0] proc_trigger,
  input wire logic ext_trig_pin,
  input wire logic timer_event,
  input wire logic [2:0] averaging_factor,
  input wire logic cfg_wr,
  input wire logic [1:0] cfg_seq,
  input wire logic [2:0] cfg_step,
  input wire logic [2:0] cfg_chan,
  input wire logic differential_select,
  input wire logic temp_sensor_select,
  input wire logic last_step_flag,
  input wire logic step_irq_flag,
  output logic conv_start,
  output logic [2:0] conv_chan,
  output logic conv_diff,
  output logic conv_temp,
  input wire logic conv_done,
  input wire logic [SAMPLE_W-1:0] conv_data,
  input wire logic rd_req,
  input wire logic [1:0] rd_seq,
  output logic [SAMPLE_W-1:0] rd_data,
  output logic rd_valid,
  output logic [15:0] fifo_count,
  output logic [3:0] overflow,
  input wire logic [3:0] ovf_clear,
  input wire logic [3:0] irq_mask,
  input wire logic [3:0] irq_clear,
  input wire logic masked_view_select,
  output logic [3:0] irq_raw,
  output logic [3:0] irq_masked,
  output logic [3:0] irq_view,
  output logic irq_out
);
  localparam int ACC_W = SAMPLE_W + 6;

  function automatic logic [3:0] seq_depth(input logic [1:0] s);
    case (s)
      2'h0: seq_depth = `ASQ_DEPTH0;
      2'h1: seq_depth = `ASQ_DEPTH1;
      2'h2: seq_depth = `ASQ_DEPTH2;
      default: seq_depth = `ASQ_DEPTH3;
    endcase
  endfunction : seq_depth

  function automatic logic [1:0] prio_of(input logic [7:0] p, input logic [1:0] s);
    prio_of = p[2*s +: 2];
  endfunction : prio_of

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  asq_pkg::asq_state_t state;
  logic [`ASQ_STEP_W-1:0] step_cfg [4][8];
  logic [3:0] pending;
  logic [1:0] cur_seq;
  logic [2:0] cur_step;
  logic [5:0] avg_cnt;
  logic [ACC_W-1:0] acc;
  logic push_v;
  logic push_irq;
  logic [1:0] push_seq;
  logic [SAMPLE_W-1:0] push_val;
  logic [2:0] wptr [4];
  logic [2:0] rptr [4];
  logic [3:0] cnt [4];
  logic [3:0] mask_q;
  logic ext_meta, ext_sync, ext_prev;
  logic [3:0] hit;
  logic [3:0] next_irq_raw;
  logic [1:0] win;
  logic [2:0] fac;
  logic [ACC_W-1:0] acc_sum;
  logic [`ASQ_STEP_W-1:0] cur_cfg;
  logic pop;
  logic [3:0] push_full;

  // ----------------------------------------------------------------
  // triggers and arbitration
  // ----------------------------------------------------------------
  // pin crosses two flops before the edge detector looks at it
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
      ext_prev <= 1'b0;
    end else begin
      ext_meta <= ext_trig_pin;
      ext_sync <= ext_meta;
      ext_prev <= ext_sync;
    end
  end

  // each sequencer listens only to the source it selects
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      case (trig_source[2*i +: 2])
        `ASQ_TRIG_PROC: hit[i] = proc_trigger[i];
        `ASQ_TRIG_EXT: hit[i] = ext_sync & ~ext_prev;
        `ASQ_TRIG_TIMER: hit[i] = timer_event;
        default: hit[i] = 1'b1; // always source fires every cycle
      endcase
    end
  end

  // best priority wins; ties are software's fault, lowest index then
  always_comb begin
    win = 2'h0;
    for (int i = 3; i >= 0; i--) begin
      if (pending[i] && (!pending[win] ||
          prio_of(sequencer_priority, 2'(i)) <= prio_of(sequencer_priority, win))) begin
        win = 2'(i);
      end
    end
  end

  // set beats the clear of a grant; disabling drops what waits
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pending <= 4'h0;
    end else begin
      pending <= ((pending & ~((state == asq_pkg::ST_IDLE && pending != 4'h0) ?
                   4'(1 << win) : 4'h0)) | hit) & seq_enable;
    end
  end

  // ----------------------------------------------------------------
  // step table
  // ----------------------------------------------------------------
  // writes beyond a sequencer's depth are discarded
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int s = 0; s < 4; s++) begin
        for (int t = 0; t < 8; t++) begin
          step_cfg[s][t] <= '0;
        end
      end
    end else if (cfg_wr && {1'b0, cfg_step} < seq_depth(cfg_seq)) begin
      step_cfg[cfg_seq][cfg_step] <= {step_irq_flag, last_step_flag, temp_sensor_select,
                                      differential_select, cfg_chan};
    end
  end

  // ----------------------------------------------------------------
  // conversion sequencing and averaging
  // ----------------------------------------------------------------
  assign fac = (averaging_factor > `ASQ_MAX_AVG) ? `ASQ_MAX_AVG : averaging_factor;
  assign acc_sum = acc + ACC_W'(conv_data);
  assign cur_cfg = step_cfg[cur_seq][cur_step];

  // averaging re-converts the same step, so throughput drops by the factor
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= asq_pkg::ST_IDLE;
      cur_seq <= 2'h0;
      cur_step <= 3'h0;
      avg_cnt <= 6'h0;
      acc <= '0;
      conv_start <= 1'b0;
      conv_chan <= 3'h0;
      conv_diff <= 1'b0;
      conv_temp <= 1'b0;
      push_v <= 1'b0;
      push_irq <= 1'b0;
      push_seq <= 2'h0;
      push_val <= '0;
    end else begin
      conv_start <= 1'b0;
      push_v <= 1'b0;
      case (state)
        asq_pkg::ST_IDLE: begin
          if (pending != 4'h0) begin
            cur_seq <= win;
            cur_step <= 3'h0;
            avg_cnt <= 6'h0;
            acc <= '0;
            state <= asq_pkg::ST_START;
          end
        end
        asq_pkg::ST_START: begin
          conv_start <= 1'b1;
          conv_chan <= cur_cfg[`ASQ_F_CHAN_LSB +: 3];
          conv_diff <= cur_cfg[`ASQ_F_DIFF];
          conv_temp <= cur_cfg[`ASQ_F_TEMP];
          state <= asq_pkg::ST_WAIT;
        end
        asq_pkg::ST_WAIT: begin
          if (conv_done) begin
            if (avg_cnt == 6'((7'h01 << fac) - 7'h01)) begin
              push_v <= 1'b1;
              push_seq <= cur_seq;
              push_val <= SAMPLE_W'(acc_sum >> fac);
              push_irq <= cur_cfg[`ASQ_F_IRQ];
              avg_cnt <= 6'h0;
              acc <= '0;
              if (cur_cfg[`ASQ_F_LAST] || {1'b0, cur_step} == seq_depth(cur_seq) - 4'h1) begin
                state <= asq_pkg::ST_IDLE;
              end else begin
                cur_step <= cur_step + 3'h1;
                state <= asq_pkg::ST_START;
              end
            end else begin
              avg_cnt <= avg_cnt + 6'h1;
              acc <= acc_sum;
              state <= asq_pkg::ST_START;
            end
          end
        end
        default: state <= asq_pkg::ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // fifos
  // ----------------------------------------------------------------
  assign pop = rd_req && cnt[rd_seq] != 4'h0;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      push_full[i] = push_v && push_seq == 2'(i) && cnt[i] == 4'(`ASQ_FIFO_DEPTH);
    end
  end

  asq_fifo_mem #(.WIDTH(SAMPLE_W), .AW(5)) u_mem (
    .ref_clk(ref_clk),
    .wr_en(push_v && !push_full[push_seq]),
    .wr_addr({push_seq, wptr[push_seq]}),
    .wr_data(push_val),
    .rd_en(pop),
    .rd_addr({rd_seq, rptr[rd_seq]}),
    .rd_data(rd_data)
  );

  // a full fifo drops the new result and flags overflow
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 4; i++) begin
        wptr[i] <= 3'h0;
        rptr[i] <= 3'h0;
        cnt[i] <= 4'h0;
      end
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= pop;
      for (int i = 0; i < 4; i++) begin
        if (push_v && push_seq == 2'(i) && !push_full[i]) begin
          wptr[i] <= wptr[i] + 3'h1;
        end
        if (pop && rd_seq == 2'(i)) begin
          rptr[i] <= rptr[i] + 3'h1;
        end
        cnt[i] <= cnt[i] + 4'(push_v && push_seq == 2'(i) && !push_full[i])
                  - 4'(pop && rd_seq == 2'(i));
      end
    end
  end

  assign fifo_count = {cnt[3], cnt[2], cnt[1], cnt[0]};

  // a new trigger while results wait unread means lost data
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      overflow <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        overflow[i] <= (overflow[i] & ~ovf_clear[i]) |
                       (hit[i] & seq_enable[i] & (cnt[i] != 4'h0)) | push_full[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupt status
  // ----------------------------------------------------------------
  // step events win over a clear or a mask opening in the same cycle
  always_comb begin
    next_irq_raw = irq_raw & ~irq_clear & ~(irq_mask & ~mask_q);
    if (push_v && push_irq) begin
      next_irq_raw[push_seq] = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_q <= 4'h0;
      irq_raw <= 4'h0;
      irq_masked <= 4'h0;
      irq_view <= 4'h0;
      irq_out <= 1'b0;
    end else begin
      mask_q <= irq_mask;
      irq_raw <= next_irq_raw;
      irq_masked <= next_irq_raw & irq_mask;
      irq_view <= masked_view_select ? (next_irq_raw & irq_mask) : next_irq_raw;
      irq_out <= |(next_irq_raw & irq_mask);
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_conv_pulse: assert property (@(posedge ref_clk) disable iff (!rst_n)
    conv_start |=> !conv_start ##1 !conv_start) else $error("conv_start not a pulse");
  a_step_bound: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state != asq_pkg::ST_IDLE |-> {1'b0, cur_step} < seq_depth(cur_seq))
    else $error("step beyond sequencer depth");
  a_grant_best: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state == asq_pkg::ST_IDLE && pending != 4'h0) |=>
    (cur_seq == $past(win) && state == asq_pkg::ST_START)) else $error("wrong grant");
  a_busy_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state == asq_pkg::ST_WAIT && !conv_done) |=> $stable(cur_seq) && $stable(cur_step))
    else $error("sequence preempted");
  a_disabled_drop: assert property (@(posedge ref_clk) disable iff (!rst_n)
    1 |=> ((pending & ~$past(seq_enable)) == 4'h0)) else $error("disabled pending");
  a_avg_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state == asq_pkg::ST_WAIT && conv_done && averaging_factor == 3'h0) |=>
    push_v && push_val == $past(conv_data)) else $error("unaveraged result missing");
  a_ovf_sticky: assert property (@(posedge ref_clk) disable iff (!rst_n)
    1 |=> ((($past(overflow) & ~$past(ovf_clear)) & ~overflow) == 4'h0))
    else $error("overflow lost without clear");
  a_mask_view: assert property (@(posedge ref_clk) disable iff (!rst_n)
    1 |=> irq_masked == (irq_raw & $past(irq_mask))) else $error("masked status wrong");
  a_mask_clears: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ((irq_mask & ~mask_q) != 4'h0 && !push_v) |=>
    ((irq_raw & $past(irq_mask & ~mask_q)) == 4'h0)) else $error("stale irq forwarded");
  a_fifo_cap: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cnt[0] <= 4'h8 && cnt[1] <= 4'h8 && cnt[2] <= 4'h8 && cnt[3] <= 4'h8)
    else $error("fifo count exceeds depth");
endmodule : asq_sequencer
`default_nettype wire

// ### hw/asq_cfg.svh
// Purpose: constants for the converter sample sequencer
// Assumes: included by bare name from hw/
// Notes: definitions only
`ifndef ASQ_CFG_SVH
`define ASQ_CFG_SVH
// ----------------------------------------------------------------
// sizes
// ----------------------------------------------------------------
`define ASQ_NSEQ 4
`define ASQ_FIFO_DEPTH 8
`define ASQ_SAMPLE_W 12
`define ASQ_DEPTH0 4'h8
`define ASQ_DEPTH1 4'h4
`define ASQ_DEPTH2 4'h4
`define ASQ_DEPTH3 4'h1
`define ASQ_MAX_AVG 3'h6
// ----------------------------------------------------------------
// trigger source codes
// ----------------------------------------------------------------
`define ASQ_TRIG_PROC 2'h0
`define ASQ_TRIG_EXT 2'h1
`define ASQ_TRIG_TIMER 2'h2
`define ASQ_TRIG_ALWAYS 2'h3
// ----------------------------------------------------------------
// step word fields
// ----------------------------------------------------------------
`define ASQ_STEP_W 7
`define ASQ_F_CHAN_LSB 0
`define ASQ_F_DIFF 3
`define ASQ_F_TEMP 4
`define ASQ_F_LAST 5
`define ASQ_F_IRQ 6
`endif

// ### hw/asq_pkg.sv
// Purpose: shared types for the converter sample sequencer
// Assumes: nothing
// Notes: constants live in asq_cfg.svh
package asq_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_START, ST_WAIT} asq_state_t;
endpackage : asq_pkg

// ### hw/asq_fifo_mem.sv
// Purpose: sample storage shared by the four sequence fifos
// Assumes: one write and one read per cycle
// Notes: read data is registered
`timescale 1ns/1ps
`default_nettype none
module asq_fifo_mem #(
  parameter int WIDTH = 12,
  parameter int AW = 5
) (
  input wire logic ref_clk,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic rd_en,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [2**AW];

  // no reset on the array keeps it mappable to ram
  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule : asq_fifo_mem
`default_nettype wire

// ### dv/asq_sequencer_test.sv
// Purpose: self-checking bench for the converter sample sequencer
// Assumes: bench plays the converter core and the processor side
// Notes: converter data encodes temp, channel, diff and a parity bit
`timescale 1ns/1ps
`default_nettype none
`include "asq_cfg.svh"
module asq_sequencer_test;
  logic ref_clk, rst_n, ext_trig_pin, timer_event, cfg_wr, conv_done, rd_req, rd_valid;
  logic differential_select, temp_sensor_select, last_step_flag, step_irq_flag;
  logic masked_view_select, conv_start, conv_diff, conv_temp, irq_out;
  logic [3:0] seq_enable, proc_trigger, ovf_clear, irq_mask, irq_clear, overflow;
  logic [3:0] irq_raw, irq_masked, irq_view;
  logic [7:0] trig_source, sequencer_priority;
  logic [2:0] averaging_factor, cfg_step, cfg_chan, conv_chan;
  logic [1:0] cfg_seq, rd_seq;
  logic [11:0] conv_data, rd_data;
  logic [15:0] fifo_count;
  int n_mismatch, cmp_count, conv_n, conv_lat;
  logic [2:0] conv_log[$];

  asq_sequencer uut (.ref_clk(ref_clk), .rst_n(rst_n), .seq_enable(seq_enable),
    .trig_source(trig_source), .sequencer_priority(sequencer_priority),
    .proc_trigger(proc_trigger), .ext_trig_pin(ext_trig_pin), .timer_event(timer_event),
    .averaging_factor(averaging_factor), .cfg_wr(cfg_wr), .cfg_seq(cfg_seq),
    .cfg_step(cfg_step), .cfg_chan(cfg_chan), .differential_select(differential_select),
    .temp_sensor_select(temp_sensor_select), .last_step_flag(last_step_flag),
    .step_irq_flag(step_irq_flag), .conv_start(conv_start), .conv_chan(conv_chan),
    .conv_diff(conv_diff), .conv_temp(conv_temp), .conv_done(conv_done),
    .conv_data(conv_data), .rd_req(rd_req), .rd_seq(rd_seq), .rd_data(rd_data),
    .rd_valid(rd_valid), .fifo_count(fifo_count), .overflow(overflow),
    .ovf_clear(ovf_clear), .irq_mask(irq_mask), .irq_clear(irq_clear),
    .masked_view_select(masked_view_select), .irq_raw(irq_raw), .irq_masked(irq_masked),
    .irq_view(irq_view), .irq_out(irq_out));

  // 20 MHz reference clock
  always #25 ref_clk = ~ref_clk;

  // ----------------------------------------------------------------
  // converter core stand-in
  // ----------------------------------------------------------------
  // data is inverted after the done pulse so a late capture cannot pass
  initial begin
    conv_done = 1'b0;
    conv_data = '0;
    forever begin
      @(posedge ref_clk);
      if (conv_start === 1'b1) begin
        conv_log.push_back(conv_chan);
        repeat (conv_lat) @(posedge ref_clk);
        conv_done <= 1'b1;
        conv_data <= {conv_temp, conv_chan, 3'h0, conv_diff, 2'h0, conv_n[0], 1'b0};
        conv_n++;
        @(posedge ref_clk);
        conv_done <= 1'b0;
        conv_data <= ~conv_data;
      end
    end
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // step word f is {irq, last, temp, diff}
  task automatic cfg(input int s, input int st, input logic [2:0] ch, input logic [3:0] f);
    @(posedge ref_clk);
    cfg_wr <= 1'b1;
    cfg_seq <= 2'(s);
    cfg_step <= 3'(st);
    cfg_chan <= ch;
    {step_irq_flag, last_step_flag, temp_sensor_select, differential_select} <= f;
    @(posedge ref_clk);
    cfg_wr <= 1'b0;
  endtask : cfg

  task automatic trig(input logic [3:0] m);
    @(posedge ref_clk);
    proc_trigger <= m;
    @(posedge ref_clk);
    proc_trigger <= 4'h0;
  endtask : trig

  // bounded wait for a fill level; a hang ends the run
  task automatic wait_fill(input int s, input logic [3:0] n);
    int i;
    for (i = 0; i < 3000; i++) begin
      @(posedge ref_clk);
      #1;
      if (fifo_count[s*4+:4] === n) break;
    end
    if (i == 3000) begin
      n_mismatch++;
      $display("[ERR] %0t fifo fill timeout", $time);
      close_out();
    end
  endtask : wait_fill

  task automatic read_chk(input int s, input logic [11:0] exp);
    @(posedge ref_clk);
    rd_req <= 1'b1;
    rd_seq <= 2'(s);
    @(posedge ref_clk);
    rd_req <= 1'b0;
    #1;
    chk(16'(rd_valid), 16'h0001, "rd_valid");
    chk(16'(rd_data), 16'(exp), "rd_data");
  endtask : read_chk

  task automatic drain(input int s);
    for (int i = 0; i < 12 && fifo_count[s*4+:4] !== 4'h0; i++) begin
      @(posedge ref_clk);
      rd_req <= 1'b1;
      rd_seq <= 2'(s);
      @(posedge ref_clk);
      rd_req <= 1'b0;
      #1;
    end
    chk(16'(fifo_count[s*4+:4]), 16'h0000, "drained count");
  endtask : drain

  task automatic run0();
    conv_n = 0;
    trig(4'h1);
    wait_fill(0, 4'h3);
  endtask : run0

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  // three steps with a repeat, stop at the last flag before step 3
  task automatic sc_steps();
    logic [11:0] exp[3] = '{12'h300, 12'h302, 12'h610};
    cfg(0, 0, 3'h3, 4'h0);
    cfg(0, 1, 3'h3, 4'h0);
    cfg(0, 2, 3'h6, 4'hD);
    cfg(0, 3, 3'h7, 4'h0);
    conv_log.delete();
    run0();
    repeat (12) @(posedge ref_clk);
    #1;
    chk(16'(fifo_count[3:0]), 16'h0003, "seq0 count");
    chk(16'(conv_log.size()), 16'h0003, "conversions");
    for (int i = 0; i < 3; i++) chk(16'(conv_log[i]), 16'(exp[i][10:8]), "chan");
    chk(16'(irq_raw), 16'h0001, "raw");
    chk(16'(irq_masked), 16'h0000, "masked");
    chk(16'(irq_out), 16'h0000, "irq_out");
    chk(16'(irq_view), 16'h0001, "raw view");
    for (int i = 0; i < 3; i++) read_chk(0, exp[i]);
  endtask : sc_steps

  // clear, stale clear on mask opening, then forwarding
  task automatic sc_irq();
    @(posedge ref_clk);
    masked_view_select <= 1'b1;
    irq_clear <= 4'h1;
    @(posedge ref_clk);
    irq_clear <= 4'h0;
    #1;
    chk(16'(irq_raw), 16'h0000, "cleared");
    chk(16'(irq_view), 16'h0000, "masked view");
    run0();
    @(posedge ref_clk);
    irq_mask <= 4'h1;
    @(posedge ref_clk);
    #1;
    chk(16'(irq_raw), 16'h0000, "stale cleared");
    drain(0);
    run0();
    chk(16'(irq_masked), 16'h0001, "masked");
    chk(16'(irq_out), 16'h0001, "irq_out");
    chk(16'(irq_view), 16'h0001, "view");
    drain(0);
  endtask : sc_irq

  // refused triggers, pin trigger, overflow set and clear
  task automatic sc_refuse();
    cfg(1, 0, 3'h1, 4'h4);
    conv_n = 0;
    @(posedge ref_clk);
    seq_enable <= 4'hE;
    trig(4'h3);
    repeat (20) @(posedge ref_clk);
    chk(16'(conv_n), 16'h0000, "refused");
    seq_enable <= 4'hF;
    ext_trig_pin <= 1'b1;
    wait_fill(1, 4'h1);
    @(posedge ref_clk);
    ext_trig_pin <= 1'b0;
    repeat (3) @(posedge ref_clk);
    ext_trig_pin <= 1'b1;
    repeat (8) @(posedge ref_clk);
    #1;
    chk(16'(overflow), 16'h0002, "overflow");
    wait_fill(1, 4'h2);
    @(posedge ref_clk);
    ext_trig_pin <= 1'b0;
    ovf_clear <= 4'h2;
    @(posedge ref_clk);
    ovf_clear <= 4'h0;
    #1;
    chk(16'(overflow), 16'h0000, "ovf cleared");
    read_chk(1, 12'h100);
    drain(1);
  endtask : sc_refuse

  // one timer event hits two sequencers; the better priority goes first
  task automatic sc_prio();
    cfg(2, 0, 3'h2, 4'h4);
    @(posedge ref_clk);
    trig_source <= 8'h28;
    sequencer_priority <= 8'hC6;
    conv_log.delete();
    @(posedge ref_clk);
    timer_event <= 1'b1;
    @(posedge ref_clk);
    timer_event <= 1'b0;
    wait_fill(1, 4'h1);
    chk(16'(fifo_count[11:8]), 16'h0001, "seq2 count");
    chk(16'(conv_log[0]), 16'h0002, "first grant");
    chk(16'(conv_log[1]), 16'h0001, "second grant");
    drain(1);
    drain(2);
  endtask : sc_prio

  // every averaging code on the single-step sequencer; code 7 acts as 64x
  task automatic sc_avg();
    conv_lat = 1;
    cfg(3, 0, 3'h5, 4'h2);
    cfg(3, 1, 3'h7, 4'h4);
    for (int n = 0; n <= 7; n++) begin
      @(posedge ref_clk);
      averaging_factor <= 3'(n);
      conv_n = 0;
      trig(4'h8);
      wait_fill(3, 4'h1);
      chk(16'(conv_n), 16'(1 << ((n > 6) ? 6 : n)), "conversions");
      read_chk(3, (n == 0) ? 12'hD00 : 12'hD01);
    end
    // a read of the empty fifo is refused and leaves the data register alone
    @(posedge ref_clk);
    rd_req <= 1'b1;
    rd_seq <= 2'h3;
    @(posedge ref_clk);
    rd_req <= 1'b0;
    #1;
    chk(16'(rd_valid), 16'h0000, "empty read refused");
    chk(16'(rd_data), 16'h0D01, "rd_data held");
  endtask : sc_avg

  // always source refills seq3 until full; later results are dropped and flagged
  task automatic sc_always();
    @(posedge ref_clk);
    averaging_factor <= 3'h0;
    trig_source <= 8'hE8;
    conv_n = 0;
    wait_fill(3, 4'h8);
    @(posedge ref_clk);
    seq_enable <= 4'h7;
    repeat (16) @(posedge ref_clk);
    #1;
    chk(16'(fifo_count[15:12]), 16'h0008, "full count");
    chk(16'(overflow), 16'h0008, "full overflow");
    read_chk(3, 12'hD00);
    drain(3);
  endtask : sc_always

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    rst_n = 1'b0;
    {ext_trig_pin, timer_event, cfg_wr, rd_req, masked_view_select} = '0;
    {differential_select, temp_sensor_select, last_step_flag, step_irq_flag} = '0;
    {proc_trigger, ovf_clear, irq_mask, irq_clear, cfg_step, cfg_chan} = '0;
    {cfg_seq, rd_seq, averaging_factor} = '0;
    seq_enable = 4'hF;
    trig_source = 8'h24;
    sequencer_priority = 8'hE4;
    n_mismatch = 0;
    cmp_count = 0;
    conv_n = 0;
    conv_lat = 4;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    #1;
    chk({conv_start, rd_valid, overflow, irq_raw, irq_out, 5'h00}, 16'h0000, "reset");
    chk(fifo_count, 16'h0000, "reset count");
    sc_steps();
    sc_irq();
    sc_refuse();
    sc_prio();
    sc_avg();
    sc_always();
    close_out();
  end
endmodule : asq_sequencer_test
`default_nettype wire
